// ### rtl/adcc_top.sv
// Conversion control of an 8-input successive-approximation converter.
// Assumes a comparator on cmp_i (high while input >= trial code) and a
// register port with one-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter logic [15:0] RC_DIV   = 16'h0190,
  parameter int          SAR_BITS = 10
)(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       cmp_i,
  input  wire logic       sleep_i,
  output logic      [9:0] sar_trial_o,
  output logic      [2:0] chan_sel_o,
  output logic            vref_ext_o,
  output logic            analog_pwr_o,
  output logic      [7:0] analog_pin_sel_o,
  output logic            busy_o,
  output logic            wake_o,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (SAR_BITS != RES_BITS) begin : g_bad_bits
    $error("adcc_top: result layout serves only 10-bit conversions");
  end
  if (RC_DIV < 16'h0002) begin : g_bad_rc
    $error("adcc_top: RC divider must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  adcc_ctl_t    ctl;
  adcc_ctl_t    next_ctl;
  logic [2:0]   clk_sel;
  logic [2:0]   next_clk_sel;
  logic [7:0]   pin_sel;
  logic [7:0]   next_pin_sel;
  logic         done_flag;
  logic         next_done_flag;
  logic         done_en;
  logic         next_done_en;
  adcc_state_t  state;
  adcc_state_t  next_state;
  logic [9:0]   trial;
  logic [9:0]   next_trial;
  logic [3:0]   bit_idx;
  logic [3:0]   next_bit_idx;
  logic [2:0]   delay_cnt;
  logic [2:0]   next_delay_cnt;
  logic         sleep_off;
  logic         next_sleep_off;
  logic         next_wake;
  logic         next_irq;
  logic         next_pwr;
  logic [7:0]   next_rdata;
  adcc_result_t result;
  adcc_result_t next_result;
  logic         load_result;

  logic         tick;
  logic         rc_sel;
  logic         wr_main;
  logic         wr_clk;
  logic         wr_pin;
  logic         wr_flags;
  logic         wr_en;
  logic         abort;
  logic [9:0]   decided;

  ////////////////////////////////////////////////////////////////////////
  // Conversion clock
  adcc_conv_clk u_conv_clk (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .run_i     (state == ST_CONV),
    .sel_i     (clk_sel),
    .rc_div_i  (RC_DIV),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    wr_main  = wr_i && (addr_i == ADDR_CTL_MAIN);
    wr_clk   = wr_i && (addr_i == ADDR_CLK_CTL);
    wr_pin   = wr_i && (addr_i == ADDR_PIN_SELECT);
    wr_flags = wr_i && (addr_i == ADDR_IRQ_FLAGS);
    wr_en    = wr_i && (addr_i == ADDR_IRQ_ENABLES);
    rc_sel   = adcc_is_rc(clk_sel);
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers, sequencer and sleep handling
  always_comb begin
    next_ctl       = ctl;
    next_clk_sel   = clk_sel;
    next_pin_sel   = pin_sel;
    next_done_flag = done_flag;
    next_done_en   = done_en;
    next_state     = state;
    next_trial     = trial;
    next_bit_idx   = bit_idx;
    next_delay_cnt = delay_cnt;
    next_sleep_off = sleep_off;
    next_wake      = 1'b0;
    next_result    = result;
    load_result    = 1'b0;
    abort          = 1'b0;
    decided        = trial;

    // Register writes; bit 5 of main control and the spare bits are
    // never stored, so they read back zero.
    if (wr_main) begin
      next_ctl.justify  = wdata_i[JUSTIFY_BIT];
      next_ctl.vref_ext = wdata_i[VREF_BIT];
      next_ctl.chan     = wdata_i[CHAN_LSB +: 3];
      next_ctl.pwr      = wdata_i[PWR_BIT];
      if (!wdata_i[GO_BIT]) begin
        next_ctl.go = 1'b0;
      end else if (wdata_i[PWR_BIT]) begin
        next_ctl.go = 1'b1;
      end else begin
        next_ctl.go = 1'b0;
      end
    end
    if (wr_clk) begin
      next_clk_sel = wdata_i[CLKSEL_LSB +: 3];
    end
    if (wr_pin) begin
      next_pin_sel = wdata_i;
    end
    if (wr_en) begin
      next_done_en = wdata_i[DONE_FLAG_BIT];
    end
    if (wr_flags && wdata_i[DONE_FLAG_BIT]) begin
      next_done_flag = 1'b0;
    end

    // Sleep on the oscillator clock stops everything at once
    if (sleep_i && !rc_sel) begin
      next_sleep_off = 1'b1;
      next_ctl.go    = 1'b0;
      abort          = 1'b1;
    end else if (!sleep_i) begin
      next_sleep_off = 1'b0;
    end
    if (!next_ctl.pwr || !next_ctl.go) begin
      abort = 1'b1;
    end

    if (abort) begin
      next_state   = ST_IDLE;
      next_trial   = 10'h000;
      next_bit_idx = 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (next_ctl.go && !sleep_off) begin
            if (rc_sel) begin
              // Lets the sleep instruction retire before sampling
              next_delay_cnt = INSTR_OSC_CYCLES - 3'h1;
              next_state     = ST_DELAY;
            end else begin
              next_trial   = 10'h200;
              next_bit_idx = 4'h9;
              next_state   = ST_CONV;
            end
          end
        end
        ST_DELAY: begin
          if (delay_cnt == 3'h0) begin
            next_trial   = 10'h200;
            next_bit_idx = 4'h9;
            next_state   = ST_CONV;
          end else begin
            next_delay_cnt = delay_cnt - 3'h1;
          end
        end
        ST_CONV: begin
          if (tick) begin
            decided          = trial;
            decided[bit_idx] = cmp_i;
            next_trial       = decided;
            if (bit_idx == 4'h0) begin
              next_state = ST_LOAD;
            end else begin
              next_trial[bit_idx - 4'h1] = 1'b1;
              next_bit_idx               = bit_idx - 4'h1;
            end
          end
        end
        ST_LOAD: begin
          next_result    = adcc_pack(ctl.justify, trial);
          load_result    = 1'b1;
          next_ctl.go    = 1'b0;
          next_done_flag = 1'b1;
          next_state     = ST_IDLE;
          if (sleep_i) begin
            if (next_done_en) begin
              next_wake = 1'b1;
            end else begin
              next_sleep_off = 1'b1;
            end
          end
        end
      endcase
    end

    // Power follows the enable bit unless sleep shut the converter down
    next_pwr = next_ctl.pwr && !next_sleep_off;
    next_irq = next_done_flag && next_done_en;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTL_MAIN:    next_rdata = {ctl.justify, ctl.vref_ext, 1'b0,
                                        ctl.chan, ctl.go, ctl.pwr};
        ADDR_CLK_CTL:     next_rdata = {1'b0, clk_sel, 4'h0};
        ADDR_PIN_SELECT:  next_rdata = pin_sel;
        ADDR_IRQ_FLAGS:   next_rdata = {1'b0, done_flag, 6'h00};
        ADDR_IRQ_ENABLES: next_rdata = {1'b0, done_en, 6'h00};
        ADDR_RESULT_HIGH: next_rdata = result.high;
        ADDR_RESULT_LOW:  next_rdata = result.low;
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctl              <= adcc_ctl_t'(CTL_MAIN_RST[6:0]);
      clk_sel          <= CLK_SEL_RST;
      pin_sel          <= PIN_SEL_RST;
      done_flag        <= IRQ_BIT_RST;
      done_en          <= IRQ_BIT_RST;
      state            <= ST_IDLE;
      trial            <= 10'h000;
      bit_idx          <= 4'h0;
      delay_cnt        <= 3'h0;
      sleep_off        <= 1'b0;
      rdata_o          <= 8'h00;
      sar_trial_o      <= 10'h000;
      chan_sel_o       <= 3'h0;
      vref_ext_o       <= 1'b0;
      analog_pwr_o     <= 1'b0;
      analog_pin_sel_o <= PIN_SEL_RST;
      busy_o           <= 1'b0;
      wake_o           <= 1'b0;
      irq_o            <= 1'b0;
    end else begin
      ctl              <= next_ctl;
      clk_sel          <= next_clk_sel;
      pin_sel          <= next_pin_sel;
      done_flag        <= next_done_flag;
      done_en          <= next_done_en;
      state            <= next_state;
      trial            <= next_trial;
      bit_idx          <= next_bit_idx;
      delay_cnt        <= next_delay_cnt;
      sleep_off        <= next_sleep_off;
      rdata_o          <= next_rdata;
      sar_trial_o      <= next_trial;
      chan_sel_o       <= next_ctl.chan;
      vref_ext_o       <= next_ctl.vref_ext;
      analog_pwr_o     <= next_pwr;
      analog_pin_sel_o <= next_pin_sel;
      busy_o           <= next_ctl.go;
      wake_o           <= next_wake;
      irq_o            <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result pair has no reset: a reset must not lose the last result
  always_ff @(posedge ref_clk_i) begin
    if (load_result) begin
      result <= next_result;
    end
  end

endmodule // adcc_top

// ### pkg/adcc_pkg.sv
// Constants, carriers and helpers of the conversion control block.
// Assumes one 100 MHz oscillator clock; register offsets are 8-bit.
package adcc_pkg;

  //////////////////////////////////////////////////////////////////////
  // Register offsets, as seen on the register port
  localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h1E;
  localparam logic [7:0] ADDR_CTL_MAIN    = 8'h1F;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] ADDR_PIN_SELECT  = 8'h91;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h9E;
  localparam logic [7:0] ADDR_CLK_CTL     = 8'h9F;

  //////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int JUSTIFY_BIT   = 7;
  localparam int VREF_BIT      = 6;
  localparam int CHAN_LSB      = 2;
  localparam int GO_BIT        = 1;
  localparam int PWR_BIT       = 0;
  localparam int CLKSEL_LSB    = 4;
  localparam int DONE_FLAG_BIT = 6;

  //////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] CTL_MAIN_RST = 8'h00;
  localparam logic [2:0] CLK_SEL_RST  = 3'h0;
  localparam logic [7:0] PIN_SEL_RST  = 8'hFF;
  localparam logic       IRQ_BIT_RST  = 1'b0;

  //////////////////////////////////////////////////////////////////////
  // Timing: oscillator periods in one instruction cycle
  localparam logic [2:0] INSTR_OSC_CYCLES = 3'h4;

  // Conversion clock divisors
  localparam logic [15:0] DIV_2  = 16'h0002;
  localparam logic [15:0] DIV_4  = 16'h0004;
  localparam logic [15:0] DIV_8  = 16'h0008;
  localparam logic [15:0] DIV_16 = 16'h0010;
  localparam logic [15:0] DIV_32 = 16'h0020;
  localparam logic [15:0] DIV_64 = 16'h0040;

  localparam int RES_BITS = 10;

  //////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       justify;
    logic       vref_ext;
    logic [2:0] chan;
    logic       go;
    logic       pwr;
  } adcc_ctl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } adcc_result_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV  = 2'b11,
    ST_LOAD  = 2'b10
  } adcc_state_t;

  //////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic adcc_is_rc(input logic [2:0] sel);
    return sel[1:0] == 2'b11;
  endfunction

  function automatic logic [15:0] adcc_divisor(input logic [2:0] sel,
                                               input logic [15:0] rc_div);
    logic [15:0] d;
    d = rc_div;
    unique case (sel)
      3'h0: d = DIV_2;
      3'h1: d = DIV_8;
      3'h2: d = DIV_32;
      3'h4: d = DIV_4;
      3'h5: d = DIV_16;
      3'h6: d = DIV_64;
      default: d = rc_div;
    endcase
    return d;
  endfunction

  function automatic adcc_result_t adcc_pack(input logic justify,
                                             input logic [9:0] code);
    adcc_result_t r;
    if (justify) begin
      r.high = {6'h00, code[9:8]};
      r.low  = code[7:0];
    end else begin
      r.high = code[9:2];
      r.low  = {code[1:0], 6'h00};
    end
    return r;
  endfunction

endpackage

// ### rtl/adcc_conv_clk.sv
// Conversion clock tick generator: one-cycle enable every N oscillator
// clocks. Assumes run is held high for the whole conversion.
`timescale 1ns/1ps
module adcc_conv_clk
  import adcc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic [2:0]  sel_i,
  input  wire logic [15:0] rc_div_i,
  output logic             tick_o
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_tick;
  logic [15:0] div;

  ////////////////////////////////////////////////////////////////////////
  // Restart on every run so each conversion sees whole periods
  always_comb begin
    div       = adcc_divisor(sel_i, rc_div_i);
    next_cnt  = 16'h0000;
    next_tick = 1'b0;
    if (run_i) begin
      if (cnt >= div - 16'h0001) begin
        next_cnt  = 16'h0000;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule // adcc_conv_clk

// ### tb/adcc_analog_model.sv
// Analog side of the converter: one fixed input level per channel and reference, and a comparator.
// Assumes the trial code and channel come straight from the control block.
`timescale 1ns/1ps
module adcc_analog_model (
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] chan_sel_i,
  input  wire logic       vref_ext_i,
  input  wire logic       analog_pwr_i,
  input  wire logic [9:0] sar_trial_i,
  output logic            cmp_o
);
  logic [9:0] level;
  logic       junk = 1'b0;

  // Level differs per channel and per reference so a wrong route shows
  assign level = {chan_sel_i, vref_ext_i ? 7'h2A : 7'h55};
  always @(posedge ref_clk_i) begin
    junk <= ~junk;
  end
  // Unpowered comparator is meaningless, so it toggles every cycle
  assign cmp_o = analog_pwr_i ? (level >= sar_trial_i) : junk;
endmodule // adcc_analog_model

// ### tb/adcc_chk.sv
// Port checker for the conversion control block.
// Assumes the register port and sleep input are its only stimulus.
`timescale 1ns/1ps
module adcc_chk
  import adcc_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sleep_i,
  input wire logic [2:0] chan_sel_o,
  input wire logic       vref_ext_o,
  input wire logic       analog_pwr_o,
  input wire logic [7:0] analog_pin_sel_o,
  input wire logic       busy_o,
  input wire logic       wake_o,
  input wire logic       irq_o
);
  // Shadow of the clock select: the RC choice is not visible at the ports
  logic [2:0] clk_q;
  logic [2:0] next_clk_q;
  logic       wr_main;

  always_comb begin
    next_clk_q = clk_q;
    if (wr_i && addr_i == ADDR_CLK_CTL) next_clk_q = wdata_i[6:4];
  end
  always_ff @(posedge ref_clk_i) begin
    clk_q <= rst_i ? CLK_SEL_RST : next_clk_q;
  end
  assign wr_main = wr_i && addr_i == ADDR_CTL_MAIN;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  a_read_idle: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
  a_go_start: assert property (
    wr_main && wdata_i[1:0] == 2'b11 && !sleep_i |=> busy_o && analog_pwr_o)
    else $error("start request not taken");
  a_pwr_off: assert property (
    wr_main && !wdata_i[0] |=> !analog_pwr_o && !busy_o)
    else $error("converter on with enable clear");
  a_ctl_copy: assert property (
    wr_main |-> ##2 chan_sel_o == $past(wdata_i[4:2], 2)
      && vref_ext_o == $past(wdata_i[6], 2))
    else $error("channel or reference not routed");
  a_pin_copy: assert property (
    wr_i && addr_i == ADDR_PIN_SELECT |-> ##2
      analog_pin_sel_o == $past(wdata_i, 2)) else $error("pin select lost");
  a_sleep_abort: assert property (
    sleep_i && clk_q[1:0] != 2'b11 |-> ##[1:2] !analog_pwr_o && !busy_o)
    else $error("sleep on divided clock did not abort");
  a_wake_pulse: assert property (
    wake_o |-> $past(sleep_i) ##1 !wake_o) else $error("bad wake pulse");
  a_irq_mask: assert property (
    wr_i && addr_i == ADDR_IRQ_ENABLES && !wdata_i[DONE_FLAG_BIT]
      |-> ##[1:2] !irq_o) else $error("masked interrupt still high");
  a_flag_hold: assert property (
    $fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(rst_i))
    else $error("interrupt dropped without software");
  a_reset_state: assert property (disable iff (1'b0)
    rst_i |=> !analog_pwr_o && !busy_o && !irq_o && chan_sel_o == 3'h0
      && analog_pin_sel_o == PIN_SEL_RST) else $error("bad reset state");
endmodule // adcc_chk

bind adcc_top adcc_chk chk_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .sleep_i, .chan_sel_o, .vref_ext_o, .analog_pwr_o,
  .analog_pin_sel_o, .busy_o, .wake_o, .irq_o);

// ### tb/adcc_tb.sv
// Self-checking bench of the conversion control block.
// Assumes the analog model on the comparator and a short RC divider.
`timescale 1ns/1ps
module adcc_tb
  import adcc_pkg::*;
();
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       sleep_i   = 1'b0;
  logic       cmp_i;
  logic [7:0] rdata_o, analog_pin_sel_o, last_hi;
  logic [9:0] sar_trial_o;
  logic [2:0] chan_sel_o;
  logic       vref_ext_o, analog_pwr_o, busy_o, wake_o, irq_o;
  int         err_count   = 0;
  int         check_count = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  adcc_top #(.RC_DIV(16'h0004)) dut_u (.ref_clk_i, .rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .cmp_i, .sleep_i, .sar_trial_o,
    .chan_sel_o, .vref_ext_o, .analog_pwr_o, .analog_pin_sel_o, .busy_o,
    .wake_o, .irq_o);
  adcc_analog_model ana_u (.ref_clk_i, .chan_sel_i(chan_sel_o),
    .vref_ext_i(vref_ext_o), .analog_pwr_i(analog_pwr_o),
    .sar_trial_i(sar_trial_o), .cmp_o(cmp_i));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp8(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, exp, input string what);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 cmp8(what, exp, rdata_o);
  endtask
  // Bounded wait for the end of a conversion, or for a wake pulse
  task automatic wait_for(input bit wake);
    int n;
    n = 0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    while ((wake ? wake_o : ~busy_o) !== 1'b1) begin
      @(posedge ref_clk_i);
      #1 n++;
      if (n > 3000) begin
        err_count++;
        close_out();
      end
    end
  endtask
  task automatic run_conv(input logic [2:0] cs, ch, input logic j, vx);
    logic [9:0] c;
    c = {ch, vx ? 7'h2A : 7'h55};
    reg_wr(ADDR_CLK_CTL, {1'b0, cs, 4'h0});
    reg_wr(ADDR_CTL_MAIN, {j, vx, 1'b0, ch, 2'b11});
    wait_for(1'b0);
    reg_rd(ADDR_CTL_MAIN, {j, vx, 1'b0, ch, 2'b01}, "go after done");
    last_hi = j ? {6'h00, c[9:8]} : c[9:2];
    reg_rd(ADDR_RESULT_HIGH, last_hi, "result high");
    reg_rd(ADDR_RESULT_LOW, j ? c[7:0] : {c[1:0], 6'h00}, "low");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    reg_rd(ADDR_CTL_MAIN, CTL_MAIN_RST, "main reset");
    reg_rd(ADDR_CLK_CTL, 8'h00, "clock reset");
    reg_rd(ADDR_PIN_SELECT, PIN_SEL_RST, "pin reset");
    reg_rd(ADDR_IRQ_FLAGS, 8'h00, "flags reset");
    reg_rd(ADDR_IRQ_ENABLES, 8'h00, "enables reset");
    reg_wr(ADDR_CTL_MAIN, 8'hFE);
    reg_rd(ADDR_CTL_MAIN, 8'hDC, "go without power");
    cmp8("busy unpowered", 8'h00, {7'h00, busy_o});
    reg_wr(ADDR_CLK_CTL, 8'hFF);
    reg_rd(ADDR_CLK_CTL, 8'h70, "clock mask");
    reg_wr(ADDR_IRQ_ENABLES, 8'hFF);
    reg_rd(ADDR_IRQ_ENABLES, 8'h40, "enable mask");
    reg_wr(ADDR_PIN_SELECT, 8'hA5);
    reg_rd(ADDR_PIN_SELECT, 8'hA5, "pin select");
    cmp8("pin output", 8'hA5, analog_pin_sel_o);
    reg_wr(8'h55, 8'hFF);
    reg_rd(8'h55, 8'h00, "unmapped");
  endtask
  task automatic t_convs();
    logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
    for (int i = 0; i < 8; i++) begin
      run_conv(codes[i % 7], i[2:0], i[0], i[1]);
    end
    run_conv(3'h7, 3'h5, 1'b1, 1'b0);
  endtask
  task automatic t_irq();
    reg_wr(ADDR_IRQ_FLAGS, 8'h40);
    reg_rd(ADDR_IRQ_FLAGS, 8'h00, "flag cleared");
    run_conv(3'h0, 3'h2, 1'b0, 1'b0);
    cmp8("irq after done", 8'h01, {7'h00, irq_o});
    reg_wr(ADDR_IRQ_ENABLES, 8'h00);
    reg_rd(ADDR_IRQ_FLAGS, 8'h40, "flag kept");
    cmp8("irq masked", 8'h00, {7'h00, irq_o});
    reg_wr(ADDR_IRQ_ENABLES, 8'h40);
    reg_rd(ADDR_IRQ_FLAGS, 8'h40, "flag still set");
    cmp8("irq unmasked", 8'h01, {7'h00, irq_o});
    reg_wr(ADDR_IRQ_FLAGS, 8'h40);
    reg_rd(ADDR_IRQ_FLAGS, 8'h00, "flag written off");
    cmp8("irq cleared", 8'h00, {7'h00, irq_o});
  endtask
  task automatic t_reset();
    reg_wr(ADDR_CLK_CTL, 8'h60);
    reg_wr(ADDR_CTL_MAIN, 8'h83);
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reg_rd(ADDR_CTL_MAIN, 8'h00, "main after reset");
    cmp8("power after reset", 8'h00, {6'h00, busy_o, analog_pwr_o});
    reg_rd(ADDR_RESULT_HIGH, last_hi, "result kept");
  endtask
  task automatic t_sleep();
    reg_wr(ADDR_CLK_CTL, 8'h60);
    reg_wr(ADDR_CTL_MAIN, 8'h03);
    repeat (20) @(posedge ref_clk_i);
    sleep_i <= 1'b1;
    reg_rd(ADDR_CTL_MAIN, 8'h01, "enable kept on abort");
    cmp8("abort in sleep", 8'h00, {6'h00, busy_o, analog_pwr_o});
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    reg_wr(ADDR_IRQ_ENABLES, 8'h40);
    reg_wr(ADDR_CLK_CTL, 8'h30);
    reg_wr(ADDR_CTL_MAIN, 8'h03);
    sleep_i <= 1'b1;
    #1 cmp8("rc start delay", 8'h00, sar_trial_o[9:2]);
    wait_for(1'b1);
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    reg_wr(ADDR_IRQ_ENABLES, 8'h00);
    reg_wr(ADDR_CTL_MAIN, 8'h03);
    sleep_i <= 1'b1;
    wait_for(1'b0);
    reg_rd(ADDR_CTL_MAIN, 8'h01, "enable kept in sleep");
    cmp8("power down in sleep", 8'h00, {7'h00, analog_pwr_o});
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_convs();
    t_irq();
    t_reset();
    t_sleep();
    close_out();
  end
endmodule // adcc_tb
